// ===== verilog/llwf_top.sv
// low-leakage wakeup unit: apb registers, pin and module wakeups, two pin filters
// What this block does
// - filter bit 7 flags a filter wakeup; writing one clears it.
// - edge field 00 off, 01 rising, 10 falling, 11 either edge.
// - filter bit 4 reads zero and ignores writes.
// - bits 3..0 choose which of sixteen wakeup pins feeds the filter.
// - two independent filters, each with select, edge and flag.
// - filter registers reset only by chip reset that is not a deep wakeup.
// - wakeup detection works only in low-leak or very-low-leak stop.
// - each pin has its own off, falling, rising or either-edge setting.
// - filtered pin must hold asserted for three oscillator cycles.
// - synchronisation adds two mclk cycles on top of those three oscillator cycles.
// - module wakeup inputs are taken without glitch filtering.
// - a module wakeup counts only when its enable bit is set.
// - in low-leak stop a wakeup raises an interrupt flow.
// - in very-low-leak stop a wakeup takes a reset flow, sets wake status.
// - after a deep wakeup I/O stays isolated until software acknowledges.
// - module flags are read-only, cleared in the peripheral itself.
`timescale 1ns/1ps
`default_nettype none
`include "llwf_defs.svh"
module llwf_top
  import llwf_pkg::*;
#(
  parameter int TICK_DIV = 200
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        chip_rst_not_vlls_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [15:0] wakeup_pins,
  input  wire logic [7:0]  module_wakeup,
  output var  logic        wake_irq,
  output var  logic        wake_reset_req,
  output var  logic        io_isolate
);
  logic [31:0] pin_en_q;
  logic [7:0]  mod_en_q;
  logic [15:0] pin_flag_q;
  logic [15:0] pin_flag_d;
  logic [7:0]  mod_flag_q;
  logic [7:0]  filt1_q;
  logic [7:0]  filt2_q;
  logic [7:0]  filt1_d;
  logic [7:0]  filt2_d;
  logic [1:0]  mode_q;
  logic        wake_stat_q;
  logic [15:0] pins_s;
  logic [15:0] pins_prev_q;
  logic [7:0]  osc_cnt_q;
  logic        osc_tick;
  logic [1:0]  flt_det;
  logic        active;
  logic        wake_any;
  logic        apb_wr;
  logic        apb_rd;
  logic [7:0]  word_idx;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic        wr_lo;
  logic [15:0] pin_hit;
  logic [7:0]  mod_hit;
  llwf_power_t power_q;

  // word index decode
  function automatic logic sel_idx(input logic [7:0] idx, input logic [7:0] want);
    sel_idx = (idx == want);
  endfunction : sel_idx

  // register map, byte address is four times the word index:
  //   0x00 pin wakeup modes, pins 0..7, two bits per pin
  //   0x08 pin wakeup modes, pins 8..15, two bits per pin
  //   0x0C module wakeup enables, one bit per module
  //   0x10 pin wakeup flags 7..0, write one to clear
  //   0x14 pin wakeup flags 15..8, write one to clear
  //   0x18 module wakeup flags, read only
  //   0x20 pin filter one: flag, edge, reserved, pin select
  //   0x24 pin filter two: same layout as filter one
  //   0x30 stop mode request, cleared by hardware on wakeup
  //   0x34 status: isolation (write one to acknowledge), wake status
  // unmapped or misaligned words answer with pslverr and are not written
  // apb decode, zero wait states
  assign apb_wr   = psel & penable & pwrite & addr_ok;  // refused words never write
  assign apb_rd   = psel & penable & ~pwrite;
  assign word_idx = paddr[9:2];
  assign wr_lo    = apb_wr & pstrb[0];
  assign addr_ok  = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0) &&
                    (sel_idx(word_idx, `LLWF_IDX_PIN_EN_LO) ||
                     sel_idx(word_idx, `LLWF_IDX_PIN_EN_HI) ||
                     sel_idx(word_idx, `LLWF_IDX_MOD_EN) ||
                     sel_idx(word_idx, `LLWF_IDX_PIN_FLAG_LO) ||
                     sel_idx(word_idx, `LLWF_IDX_PIN_FLAG_HI) ||
                     sel_idx(word_idx, `LLWF_IDX_MOD_FLAG) ||
                     sel_idx(word_idx, `LLWF_IDX_FILT1) ||
                     sel_idx(word_idx, `LLWF_IDX_FILT2) ||
                     sel_idx(word_idx, `LLWF_IDX_MODE) ||
                     sel_idx(word_idx, `LLWF_IDX_STATUS));

  // read mux; reserved filter bit forced to zero
  assign rd_mux =
    sel_idx(word_idx, `LLWF_IDX_PIN_EN_LO)   ? {16'h0, pin_en_q[15:0]} :
    sel_idx(word_idx, `LLWF_IDX_PIN_EN_HI)   ? {16'h0, pin_en_q[31:16]} :
    sel_idx(word_idx, `LLWF_IDX_MOD_EN)      ? {24'h0, mod_en_q} :
    sel_idx(word_idx, `LLWF_IDX_PIN_FLAG_LO) ? {24'h0, pin_flag_q[7:0]} :
    sel_idx(word_idx, `LLWF_IDX_PIN_FLAG_HI) ? {24'h0, pin_flag_q[15:8]} :
    sel_idx(word_idx, `LLWF_IDX_MOD_FLAG)    ? {24'h0, mod_flag_q} :
    sel_idx(word_idx, `LLWF_IDX_FILT1)       ? {24'h0, filt1_q & 8'hEF} :
    sel_idx(word_idx, `LLWF_IDX_FILT2)       ? {24'h0, filt2_q & 8'hEF} :
    sel_idx(word_idx, `LLWF_IDX_MODE)        ? {30'h0, mode_q} :
    sel_idx(word_idx, `LLWF_IDX_STATUS)      ? {30'h0, wake_stat_q, io_isolate} : 32'h0;

  // low-power oscillator tick from mclk divider
  // the tick is one mclk wide, once every TICK_DIV cycles
  assign osc_tick = (osc_cnt_q == 8'(TICK_DIV - 1));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) osc_cnt_q <= 8'h0;
    else osc_cnt_q <= osc_tick ? 8'h0 : osc_cnt_q + 8'h1;
  end

  // pins pass two flip-flops before any logic
  // a pin change reaches pins_s two mclk edges after it arrives
  llwf_sync2 #(.WIDTH(16)) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (wakeup_pins),
    .sync_out (pins_s)
  );

  // detection only in a stop mode
  assign active = (power_q == LLWF_STOP_LIGHT) || (power_q == LLWF_STOP_DEEP);

  // filter timing, in low-power oscillator ticks:
  //   tick 0  the selected pin shows the chosen edge and arms the window
  //   tick 1  the pin still holds its new level
  //   tick 2  the pin still holds its new level, detect pulses for one mclk
  // the pin synchroniser adds two more mclk cycles on top of that;
  // a level change back inside the window drops the partial count
  // software must let five ticks pass after reprogramming a filter
  // before it requests a stop mode, so the edge history is valid
  // two independent filters
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_flt
      llwf_glitch_filter u_flt (
        .mclk     (mclk),
        .nrst     (nrst),
        .osc_tick (osc_tick),
        .active   (active),
        .pins     (pins_s),
        .pin_sel  (gi == 0 ? filt1_q[`LLWF_FLT_SEL_HI:`LLWF_FLT_SEL_LO]
                           : filt2_q[`LLWF_FLT_SEL_HI:`LLWF_FLT_SEL_LO]),
        .edge_sel (gi == 0 ? filt1_q[`LLWF_FLT_EDGE_HI:`LLWF_FLT_EDGE_LO]
                           : filt2_q[`LLWF_FLT_EDGE_HI:`LLWF_FLT_EDGE_LO]),
        .detect   (flt_det[gi])
      );
    end
    // per-pin unfiltered edge detect, two-bit mode per pin
    // a pin flag is set even when another source wakes in the same cycle
    for (gi = 0; gi < 16; gi++) begin : g_pin
      assign pin_hit[gi] = active & llwf_edge_hit(pin_en_q[2*gi+1 -: 2],
                                                  pins_s[gi] & ~pins_prev_q[gi],
                                                  ~pins_s[gi] & pins_prev_q[gi]);
    end
  endgenerate

  // module wakeups are unfiltered and gated by enable
  assign mod_hit  = {8{active}} & mod_en_q & module_wakeup;
  assign wake_any = (|pin_hit) | (|mod_hit) | (|flt_det);

  // pin flags: hardware set wins over write-one clear
  assign pin_flag_d = pin_hit | (pin_flag_q &
    ~((wr_lo && sel_idx(word_idx, `LLWF_IDX_PIN_FLAG_LO)) ? {8'h0, pwdata[7:0]} :
      (wr_lo && sel_idx(word_idx, `LLWF_IDX_PIN_FLAG_HI)) ? {pwdata[7:0], 8'h0} : 16'h0));

  // filter register next values; bit 4 never stored
  assign filt1_d = {flt_det[0] | (filt1_q[7] &
                    ~(wr_lo && sel_idx(word_idx, `LLWF_IDX_FILT1) && pwdata[7])),
                    (wr_lo && sel_idx(word_idx, `LLWF_IDX_FILT1)) ? pwdata[6:5] : filt1_q[6:5],
                    1'b0,
                    (wr_lo && sel_idx(word_idx, `LLWF_IDX_FILT1)) ? pwdata[3:0] : filt1_q[3:0]};
  assign filt2_d = {flt_det[1] | (filt2_q[7] &
                    ~(wr_lo && sel_idx(word_idx, `LLWF_IDX_FILT2) && pwdata[7])),
                    (wr_lo && sel_idx(word_idx, `LLWF_IDX_FILT2)) ? pwdata[6:5] : filt2_q[6:5],
                    1'b0,
                    (wr_lo && sel_idx(word_idx, `LLWF_IDX_FILT2)) ? pwdata[3:0] : filt2_q[3:0]};

  // filter registers on their own chip reset
  // this reset is the chip reset that is not a deep wakeup, so the
  // selection survives a deep wakeup and the flag can tell software
  // which filter woke the device
  always_ff @(posedge mclk or negedge chip_rst_not_vlls_n) begin
    if (!chip_rst_not_vlls_n) begin
      filt1_q <= `LLWF_FLT_RESET;
      filt2_q <= `LLWF_FLT_RESET;
    end else begin
      filt1_q <= filt1_d;
      filt2_q <= filt2_d;
    end
  end

  // enables, flags and previous pin levels
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_en_q    <= 32'h0;
      mod_en_q    <= 8'h0;
      pin_flag_q  <= 16'h0;
      mod_flag_q  <= 8'h0;
      pins_prev_q <= 16'h0;
    end else begin
      pins_prev_q <= pins_s;
      pin_flag_q  <= pin_flag_d;
      mod_flag_q  <= mod_hit | (mod_flag_q & module_wakeup);
      if (apb_wr && pstrb[1:0] == 2'h3 && sel_idx(word_idx, `LLWF_IDX_PIN_EN_LO))
        pin_en_q[15:0] <= pwdata[15:0];
      if (apb_wr && pstrb[1:0] == 2'h3 && sel_idx(word_idx, `LLWF_IDX_PIN_EN_HI))
        pin_en_q[31:16] <= pwdata[15:0];
      if (wr_lo && sel_idx(word_idx, `LLWF_IDX_MOD_EN))
        mod_en_q <= pwdata[7:0];
    end
  end

  // power state sequencing:
  //   run    a mode write moves to a stop state at the next edge
  //   light  any wakeup pulses wake_irq and returns to run
  //   deep   any wakeup pulses wake_reset_req, latches wake status
  //          and raises io_isolate until software acknowledges
  // only a wakeup or a reset leaves a stop state; clearing the mode
  // word does not, since the processor cannot run to write it there
  // an acknowledge in the same cycle as a deep wakeup loses, so the
  // isolation from that wakeup is never dropped by a stale write
  // power state, wake outputs and isolation
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      power_q        <= LLWF_RUN;
      mode_q         <= 2'h0;
      wake_irq       <= 1'b0;
      wake_reset_req <= 1'b0;
      wake_stat_q    <= 1'b0;
      io_isolate     <= 1'b0;
    end else begin
      wake_irq       <= 1'b0;
      wake_reset_req <= 1'b0;
      if (wr_lo && sel_idx(word_idx, `LLWF_IDX_MODE))
        mode_q <= pwdata[1:0];
      case (power_q)
        LLWF_RUN: begin
          if (mode_q[`LLWF_MODE_DEEP_BIT]) power_q <= LLWF_STOP_DEEP;
          else if (mode_q[`LLWF_MODE_LIGHT_BIT]) power_q <= LLWF_STOP_LIGHT;
        end
        LLWF_STOP_LIGHT: begin
          if (wake_any) begin
            wake_irq <= 1'b1;
            power_q  <= LLWF_RUN;
            mode_q   <= 2'h0;
          end
        end
        LLWF_STOP_DEEP: begin
          if (wake_any) begin
            wake_reset_req <= 1'b1;
            wake_stat_q    <= 1'b1;
            io_isolate     <= 1'b1;
            power_q        <= LLWF_RUN;
            mode_q         <= 2'h0;
          end
        end
        default: power_q <= LLWF_RUN;
      endcase
      if (wr_lo && sel_idx(word_idx, `LLWF_IDX_STATUS) && pwdata[`LLWF_STAT_ACK_BIT] &&
          !(power_q == LLWF_STOP_DEEP && wake_any))
        io_isolate <= 1'b0;
    end
  end

  // apb answer registered, no wait cycle
  // pready answers in the access cycle right after setup; prdata and
  // pslverr stand with it for that one cycle and read zero otherwise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata  <= (psel & ~penable & ~pwrite & addr_ok) ? rd_mux : 32'h0;
    end
  end
endmodule : llwf_top
`default_nettype wire

// ===== verilog/llwf_defs.svh
// register offsets, field positions, reset values and timing counts of the wakeup unit
`ifndef LLWF_DEFS_SVH
`define LLWF_DEFS_SVH
// register word indices; byte address is four times the index
`define LLWF_IDX_PIN_EN_LO   8'h00
`define LLWF_IDX_PIN_EN_HI   8'h02
`define LLWF_IDX_MOD_EN      8'h03
`define LLWF_IDX_PIN_FLAG_LO 8'h04
`define LLWF_IDX_PIN_FLAG_HI 8'h05
`define LLWF_IDX_MOD_FLAG    8'h06
`define LLWF_IDX_FILT1       8'h08
`define LLWF_IDX_FILT2       8'h09
`define LLWF_IDX_MODE        8'h0C
`define LLWF_IDX_STATUS      8'h0D
// filter register fields
`define LLWF_FLT_FLAG_BIT    7
`define LLWF_FLT_EDGE_HI     6
`define LLWF_FLT_EDGE_LO     5
`define LLWF_FLT_RSVD_BIT    4
`define LLWF_FLT_SEL_HI      3
`define LLWF_FLT_SEL_LO      0
`define LLWF_FLT_RESET       8'h00
// mode register fields
`define LLWF_MODE_LIGHT_BIT  0
`define LLWF_MODE_DEEP_BIT   1
// status register fields
`define LLWF_STAT_ISO_BIT    0
`define LLWF_STAT_WAKE_BIT   1
`define LLWF_STAT_ACK_BIT    0
// glitch window in low-power oscillator cycles
`define LLWF_GLITCH_CYCLES   3'h3
`endif

// ===== verilog/llwf_pkg.sv
// types shared by the wakeup unit
package llwf_pkg;
  typedef enum logic [1:0] {
    LLWF_EDGE_OFF  = 2'h0,
    LLWF_EDGE_RISE = 2'h1,
    LLWF_EDGE_FALL = 2'h2,
    LLWF_EDGE_ANY  = 2'h3
  } llwf_edge_t;
  typedef enum logic [1:0] {
    LLWF_RUN,
    LLWF_STOP_LIGHT,
    LLWF_STOP_DEEP
  } llwf_power_t;

  // true when the edge mode accepts this transition
  function automatic logic llwf_edge_hit(input logic [1:0] mode, input logic rise,
                                         input logic fall);
    llwf_edge_hit = (mode[0] & rise) | (mode[1] & fall);
  endfunction : llwf_edge_hit
endpackage : llwf_pkg

// ===== verilog/llwf_sync2.sv
// two-flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module llwf_sync2 #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : llwf_sync2
`default_nettype wire

// ===== verilog/llwf_glitch_filter.sv
// one digital pin filter: pin mux, edge detect and three-cycle glitch window
`timescale 1ns/1ps
`default_nettype none
`include "llwf_defs.svh"
module llwf_glitch_filter
  import llwf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        osc_tick,
  input  wire logic        active,
  input  wire logic [15:0] pins,
  input  wire logic [3:0]  pin_sel,
  input  wire logic [1:0]  edge_sel,
  output var  logic        detect
);
  logic       sel_pin;
  logic       prev_q;
  logic       armed_q;
  logic       want_q;
  logic [2:0] count_q;
  logic       rise;
  logic       fall;

  assign sel_pin = pins[pin_sel];
  assign rise    = sel_pin & ~prev_q;
  assign fall    = ~sel_pin & prev_q;

  // edge arms the window; pin must hold its new level for three ticks
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
      want_q  <= 1'b0;
      count_q <= 3'h0;
      detect  <= 1'b0;
    end else begin
      detect <= 1'b0;
      if (osc_tick) begin
        prev_q <= sel_pin;
        if (!active || edge_sel == LLWF_EDGE_OFF) begin
          armed_q <= 1'b0;
          count_q <= 3'h0;
        end else if (llwf_edge_hit(edge_sel, rise, fall)) begin
          armed_q <= 1'b1;
          want_q  <= sel_pin;
          count_q <= 3'h1;
        end else if (armed_q && sel_pin != want_q) begin
          armed_q <= 1'b0;
          count_q <= 3'h0;
        end else if (armed_q) begin
          if (count_q == `LLWF_GLITCH_CYCLES - 3'h1) begin
            armed_q <= 1'b0;
            detect  <= 1'b1;
            count_q <= 3'h0;
          end else begin
            count_q <= count_q + 3'h1;
          end
        end
      end
    end
  end
endmodule : llwf_glitch_filter
`default_nettype wire

// ===== verif/llwf_wake_src.sv
// wakeup source model: external wakeup pins and peripheral wakeup requests
`timescale 1ns/1ps
`default_nettype none
module llwf_wake_src (
  input  wire logic        mclk,
  input  wire logic [15:0] pin_req,
  input  wire logic [7:0]  mod_req,
  output var  logic [15:0] wakeup_pins,
  output var  logic [7:0]  module_wakeup
);
  // pins are plain digital input levels, never floating
  always_ff @(posedge mclk) begin
    wakeup_pins <= pin_req;
  end
  // a peripheral holds its request until its own flag is cleared
  always_ff @(posedge mclk) begin
    module_wakeup <= mod_req;
  end
endmodule : llwf_wake_src
`default_nettype wire

// ===== verif/llwf_checker.sv
// checker: apb handshake, filter read-back and wake output relations
`timescale 1ns/1ps
`default_nettype none
`include "llwf_defs.svh"
module llwf_checker #(
  parameter int TICK_DIV = 200
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        chip_rst_not_vlls_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] wakeup_pins,
  input wire logic [7:0]  module_wakeup,
  input wire logic        wake_irq,
  input wire logic        wake_reset_req,
  input wire logic        io_isolate
);
  // isolation acknowledge write and filter register read
  wire logic ack_wr = psel & penable & pwrite & pwdata[0] & pstrb[0]
                      & (paddr == {22'h0, `LLWF_IDX_STATUS, 2'h0});
  wire logic flt_rd = pready & ~pwrite & (paddr[31:3] == 29'h4);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  flt_rsvd_a: assert property (flt_rd |-> prdata[4] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("reserved filter bits not zero");
  wake_excl_a: assert property (!(wake_irq && wake_reset_req))
    else $error("interrupt and reset wake together");
  irq_pulse_a: assert property (wake_irq |=> !wake_irq)
    else $error("wake interrupt longer than one cycle");
  iso_set_a: assert property (wake_reset_req |-> ##[0:1] io_isolate)
    else $error("isolation not raised after deep wake");
  iso_hold_a: assert property (io_isolate && !ack_wr |=> io_isolate)
    else $error("isolation dropped without acknowledge");
  iso_cause_a: assert property ($rose(io_isolate) |-> wake_reset_req || $past(wake_reset_req))
    else $error("isolation raised without deep wake");
  cover property (wake_irq);
  cover property (wake_reset_req);
  cover property (pslverr);
  cover property ($fell(io_isolate));
endmodule : llwf_checker
bind llwf_top llwf_checker #(.TICK_DIV(TICK_DIV)) llwf_checker_i (.mclk(mclk), .nrst(nrst),
  .chip_rst_not_vlls_n(chip_rst_not_vlls_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wakeup_pins(wakeup_pins), .module_wakeup(module_wakeup),
  .wake_irq(wake_irq), .wake_reset_req(wake_reset_req), .io_isolate(io_isolate));
`default_nettype wire

// ===== verif/testbench.sv
// testbench: register access, filter, module and pin wakeup sequences
`timescale 1ns/1ps
`default_nettype none
`include "llwf_defs.svh"
module testbench;
  localparam int TICK = 4;
  localparam int W = 5 * TICK + 4;
  localparam logic [31:0] A_F1 = {22'h0, `LLWF_IDX_FILT1, 2'h0};
  localparam logic [31:0] A_F2 = {22'h0, `LLWF_IDX_FILT2, 2'h0};
  localparam logic [31:0] A_MODE = {22'h0, `LLWF_IDX_MODE, 2'h0};
  localparam logic [31:0] A_STAT = {22'h0, `LLWF_IDX_STATUS, 2'h0};
  localparam logic [31:0] A_MEN = {22'h0, `LLWF_IDX_MOD_EN, 2'h0};
  localparam logic [31:0] A_MFL = {22'h0, `LLWF_IDX_MOD_FLAG, 2'h0};
  localparam logic [31:0] A_PEN = {22'h0, `LLWF_IDX_PIN_EN_LO, 2'h0};
  localparam logic [31:0] A_PFL = {22'h0, `LLWF_IDX_PIN_FLAG_LO, 2'h0};
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        crst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] pin_req = 16'h0;
  logic [7:0]  mod_req = 8'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wake_irq;
  logic        wake_reset_req;
  logic        io_isolate;
  logic        last_err;
  wire  logic [15:0] wakeup_pins;
  wire  logic [7:0]  module_wakeup;
  int          miscompares = 0;
  int          n_tests = 0;
  int          irq_cnt = 0;
  int          rst_cnt = 0;
  // clock and wake pulse counters
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) irq_cnt <= irq_cnt + int'(wake_irq === 1'b1);
  always @(posedge mclk) rst_cnt <= rst_cnt + int'(wake_reset_req === 1'b1);
  llwf_top #(.TICK_DIV(TICK)) llwf_top_i (.mclk(mclk), .nrst(nrst), .chip_rst_not_vlls_n(crst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wakeup_pins(wakeup_pins), .module_wakeup(module_wakeup), .wake_irq(wake_irq),
    .wake_reset_req(wake_reset_req), .io_isolate(io_isolate));
  llwf_wake_src llwf_wake_src_i (.mclk(mclk), .pin_req(pin_req), .mod_req(mod_req),
    .wakeup_pins(wakeup_pins), .module_wakeup(module_wakeup));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer: setup, then access until ready
  task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [31:0] a, exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rd
  task automatic pmove(input int i, input logic v);
    pin_req[i] <= v;
    repeat (W) @(posedge mclk);
  endtask : pmove
  // a reset that keeps the filter registers; only way out of a stop without a wakeup
  task automatic pulse_rst();
    nrst <= 1'b0;
    @(posedge mclk);
    nrst <= 1'b1;
  endtask : pulse_rst
  task automatic results();
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    results();
  end
  // main sequence
  initial begin
    logic [7:0] f;
    int         c;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    crst_n <= 1'b1;
    rd(A_F1, 32'h0);
    wr(A_F1, 32'hFF);
    rd(A_F1, 32'h6F);
    wr(A_F2, 32'h5A);
    rd(A_F2, 32'h4A);
    rd(A_F1, 32'h6F);
    rd(32'h3C, 32'h0);
    chk(last_err, 1'b1);
    wr(32'h420, 32'h0);
    chk(last_err, 1'b1);
    rd(A_F1, 32'h6F);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(A_F1, 32'h6F);
    crst_n <= 1'b0;
    @(posedge mclk);
    crst_n <= 1'b1;
    rd(A_F1, 32'h0);
    for (int e = 0; e < 4; e++) begin
      f = {1'b0, 2'(e), 5'h05};
      c = irq_cnt;
      wr(A_F1, {24'h0, f});
      repeat (5 * TICK) @(posedge mclk);
      pmove(5, 1'b1);
      pmove(5, 1'b0);
      chk(irq_cnt, c);
      wr(A_MODE, 32'h1);
      pmove(5, 1'b1);
      chk(irq_cnt, c + e % 2);
      pmove(5, 1'b0);
      chk(irq_cnt, c + int'(e > 0));
      rd(A_F1, {24'h0, e > 0, f[6:0]});
      wr(A_F1, {24'h0, 1'b1, f[6:0]});
      rd(A_F1, {24'h0, f});
      wr(A_MODE, 32'h0);
      pulse_rst();
    end
    c = irq_cnt;
    wr(A_F1, 32'h25);
    repeat (5 * TICK) @(posedge mclk);
    wr(A_MODE, 32'h1);
    pin_req[5] <= 1'b1;
    repeat (TICK) @(posedge mclk);
    pin_req[5] <= 1'b0;
    repeat (W) @(posedge mclk);
    chk(irq_cnt, c);
    rd(A_F1, 32'h25);
    wr(A_MODE, 32'h0);
    pulse_rst();
    wr(A_F2, 32'h4F);
    pmove(15, 1'b1);
    wr(A_MODE, 32'h2);
    pmove(15, 1'b0);
    chk(rst_cnt, 1);
    chk(irq_cnt, c);
    chk(io_isolate, 1'b1);
    rd(A_F2, 32'hCF);
    rd(A_F1, 32'h25);
    rd(A_STAT, 32'h3);
    wr(A_F2, 32'hCF);
    rd(A_F2, 32'h4F);
    wr(A_STAT, 32'h1);
    @(posedge mclk);
    chk(io_isolate, 1'b0);
    wr(A_MEN, 32'h4);
    wr(A_MODE, 32'h1);
    mod_req <= 8'h02;
    repeat (W) @(posedge mclk);
    chk(irq_cnt, c);
    mod_req <= 8'h04;
    repeat (6) @(posedge mclk);
    chk(irq_cnt, c + 1);
    rd(A_MFL, 32'h4);
    wr(A_MFL, 32'hFF);
    rd(A_MFL, 32'h4);
    mod_req <= 8'h00;
    repeat (2) @(posedge mclk);
    rd(A_MFL, 32'h0);
    wr(A_PEN, 32'h40);
    wr(A_MODE, 32'h1);
    pmove(3, 1'b1);
    chk(irq_cnt, c + 2);
    rd(A_PFL, 32'h8);
    wr(A_PFL, 32'h8);
    rd(A_PFL, 32'h0);
    results();
  end
endmodule : testbench
`default_nettype wire
